/* File: hdl/rbt_pkg.sv */
// Constants shared by the registered bus transceiver and its capture log
package rbt_pkg;
	// Section geometry and layout of one section's synchronised pin vector
	localparam int SEC_N    = 2;
	localparam int SEC_BITS = 8;
	localparam int P_A      = 0;
	localparam int P_B      = 8;
	localparam int P_OEN    = 16;
	localparam int P_DIR    = 17;
	localparam int P_SAB    = 18;
	localparam int P_SBA    = 19;
	localparam int P_CAB    = 20;
	localparam int P_CBA    = 21;
	localparam int SEC_W    = 22;
	localparam int PIN_W    = SEC_N * SEC_W;

	// Cycles after reset before capture edges are trusted
	localparam logic [1:0] SETTLE_CYC = 2'h3;

	// Register map, byte offsets
	localparam int          AXI_AW     = 4;
	localparam logic [3:0]  OFF_CTRL   = 4'h0;
	localparam logic [3:0]  OFF_STATUS = 4'h4;
	localparam logic [3:0]  OFF_LOG    = 4'h8;
	localparam logic [3:0]  OFF_STORED = 4'hC;

	// Control register fields and reset value
	localparam int          CTRL_LOG_AB  = 0;
	localparam int          CTRL_LOG_BA  = 1;
	localparam int          CTRL_CLR_OVF = 2;
	localparam logic [1:0]  CTRL_RST     = 2'h0;

	// Status register fields
	localparam int ST_NONEMPTY = 0;
	localparam int ST_OVF      = 1;
	localparam int ST_PEND     = 4;
	localparam int ST_PINS     = 8;

	// Capture log entry: {direction, section, data}
	localparam int LOG_W       = 10;
	localparam int LOG_DEPTH   = 8;
	localparam int LOG_VALID   = 31;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rbt_pkg

/* File: hdl/rbt_fifo.sv */
// Small synchronous FIFO for the capture log
`timescale 1ns/1ps
`default_nettype none
module rbt_fifo
	import rbt_pkg::*;
#(
	parameter int WIDTH = LOG_W,
	parameter int DEPTH = LOG_DEPTH
)
(
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_check
		$error("rbt_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr;
		logic [AW:0]                 rd;
	} rbt_fifo_t;

	rbt_fifo_t st;
	rbt_fifo_t nx;
	logic      full;
	logic      empty;

	assign empty     = (st.wr == st.rd);
	assign full      = (st.wr[AW-1:0] == st.rd[AW-1:0]) && !empty;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = st.mem[st.rd[AW-1:0]];

	always_comb
	begin
		nx = st;
		if (in_valid && !full)
		begin
			nx.mem[st.wr[AW-1:0]] = in_data;
			nx.wr = st.wr + 1'b1;
		end
		if (out_ready && !empty)
			nx.rd = st.rd + 1'b1;
		if (sys_rst)
		begin
			nx.wr = '0;
			nx.rd = '0;
		end
	end

	always_ff @(posedge core_clk)
		st <= nx;
endmodule : rbt_fifo
`default_nettype wire

/* File: hdl/rbt_top.sv */
// Registered bus transceiver: two 8-bit sections with capture log
`timescale 1ns/1ps
`default_nettype none
module rbt_top
	import rbt_pkg::*;
#(
	parameter int LOG_FIFO_DEPTH = LOG_DEPTH
)
(
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic [SEC_N*SEC_BITS-1:0] port_a_lines_in,
	output logic      [SEC_N*SEC_BITS-1:0] port_a_lines_out,
	output logic      [SEC_N*SEC_BITS-1:0] port_a_lines_oe,
	input  wire logic [SEC_N*SEC_BITS-1:0] port_b_lines_in,
	output logic      [SEC_N*SEC_BITS-1:0] port_b_lines_out,
	output logic      [SEC_N*SEC_BITS-1:0] port_b_lines_oe,
	input  wire logic [SEC_N-1:0]          output_enable_n,
	input  wire logic [SEC_N-1:0]          transfer_way_select,
	input  wire logic [SEC_N-1:0]          a_to_b_source_select,
	input  wire logic [SEC_N-1:0]          b_to_a_source_select,
	input  wire logic [SEC_N-1:0]          a_to_b_capture_clock,
	input  wire logic [SEC_N-1:0]          b_to_a_capture_clock,
	input  wire logic [AXI_AW-1:0]         s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic      [1:0]                s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [AXI_AW-1:0]         s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready
);
	if (LOG_FIFO_DEPTH < 2)
	begin : g_check
		$error("rbt_top: LOG_FIFO_DEPTH must be at least 2");
	end

	typedef struct packed {
		logic [PIN_W-1:0]                s1;
		logic [PIN_W-1:0]                s2;
		logic [SEC_N-1:0][1:0]           clk_prev;
		logic [1:0]                      settle;
		logic [SEC_N-1:0][SEC_BITS-1:0]  ab;
		logic [SEC_N-1:0][SEC_BITS-1:0]  ba;
		logic [SEC_N-1:0][SEC_BITS-1:0]  a_out;
		logic [SEC_N-1:0][SEC_BITS-1:0]  b_out;
		logic [SEC_N-1:0]                a_oe;
		logic [SEC_N-1:0]                b_oe;
		logic [1:0]                      log_en;
		logic                            overflow;
		logic [2*SEC_N-1:0]              pend;
		logic [2*SEC_N-1:0][LOG_W-1:0]   hold;
		logic                            aw_seen;
		logic [AXI_AW-1:0]               waddr;
		logic                            w_seen;
		logic [31:0]                     wdata;
		logic [3:0]                      wstrb;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic                            rvalid;
		logic [31:0]                     rdata;
		logic [1:0]                      rresp;
	} rbt_state_t;

	rbt_state_t         st;
	rbt_state_t         nx;
	logic [PIN_W-1:0]   pin_raw;
	logic               log_in_valid;
	logic               log_in_ready;
	logic [LOG_W-1:0]   log_in_data;
	logic               log_out_valid;
	logic               log_out_ready;
	logic [LOG_W-1:0]   log_out_data;
	logic [1:0]         log_sel;
	logic               settled;
	logic               a_have;
	logic               w_have;
	logic [AXI_AW-1:0]  wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	logic [SEC_BITS-1:0] live_a;
	logic [SEC_BITS-1:0] live_b;
	logic               edge_ab;
	logic               edge_ba;
	logic [31:0]        status_word;

	// Gather each section's pins into one vector for synchronising
	always_comb
	begin
		pin_raw = '0;
		for (int s = 0; s < SEC_N; s++)
		begin
			pin_raw[s*SEC_W+P_A +: SEC_BITS] =
				port_a_lines_in[s*SEC_BITS +: SEC_BITS];
			pin_raw[s*SEC_W+P_B +: SEC_BITS] =
				port_b_lines_in[s*SEC_BITS +: SEC_BITS];
			pin_raw[s*SEC_W+P_OEN] = output_enable_n[s];
			pin_raw[s*SEC_W+P_DIR] = transfer_way_select[s];
			pin_raw[s*SEC_W+P_SAB] = a_to_b_source_select[s];
			pin_raw[s*SEC_W+P_SBA] = b_to_a_source_select[s];
			pin_raw[s*SEC_W+P_CAB] = a_to_b_capture_clock[s];
			pin_raw[s*SEC_W+P_CBA] = b_to_a_capture_clock[s];
		end
	end

	// Lowest pending log source wins the FIFO write port
	always_comb
	begin
		log_sel = 2'h0;
		for (int k = 2*SEC_N-1; k >= 0; k--)
			if (st.pend[k])
				log_sel = 2'(k);
	end

	assign log_in_valid = |st.pend;
	assign log_in_data  = st.hold[log_sel];
	assign settled      = (st.settle == SETTLE_CYC);

	// AXI handshakes
	assign s_axi_awready = !st.aw_seen && !st.bvalid;
	assign s_axi_wready  = !st.w_seen && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign log_out_ready = s_axi_arvalid && !st.rvalid &&
		(s_axi_araddr == OFF_LOG);

	// Status word
	always_comb
	begin
		status_word = '0;
		status_word[ST_NONEMPTY] = log_out_valid;
		status_word[ST_OVF] = st.overflow;
		status_word[ST_PEND +: 2*SEC_N] = st.pend;
		for (int s = 0; s < SEC_N; s++)
			status_word[ST_PINS+4*s +: 4] = st.s2[s*SEC_W+P_OEN +: 4];
	end

	always_comb
	begin
		nx = st;
		live_a = '0;
		live_b = '0;
		edge_ab = 1'b0;
		edge_ba = 1'b0;
		nx.s1 = pin_raw;
		nx.s2 = st.s1;
		if (!settled)
			nx.settle = st.settle + 2'h1;

		// Write channel: address and data may arrive in either order
		a_have  = st.aw_seen || (s_axi_awvalid && s_axi_awready);
		w_have  = st.w_seen || (s_axi_wvalid && s_axi_wready);
		wr_addr = st.aw_seen ? st.waddr : s_axi_awaddr;
		wr_data = st.w_seen ? st.wdata : s_axi_wdata;
		wr_strb = st.w_seen ? st.wstrb : s_axi_wstrb;
		if (st.bvalid && s_axi_bready)
			nx.bvalid = 1'b0;
		if (a_have && w_have)
		begin
			nx.aw_seen = 1'b0;
			nx.w_seen = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = RESP_SLVERR;
			if (wr_addr == OFF_CTRL)
			begin
				nx.bresp = RESP_OKAY;
				if (wr_strb[0])
				begin
					nx.log_en[0] = wr_data[CTRL_LOG_AB];
					nx.log_en[1] = wr_data[CTRL_LOG_BA];
					if (wr_data[CTRL_CLR_OVF])
						nx.overflow = 1'b0;
				end
			end
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				nx.aw_seen = 1'b1;
				nx.waddr = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				nx.w_seen = 1'b1;
				nx.wdata = s_axi_wdata;
				nx.wstrb = s_axi_wstrb;
			end
		end

		// Read channel
		if (st.rvalid && s_axi_rready)
			nx.rvalid = 1'b0;
		if (s_axi_arvalid && !st.rvalid)
		begin
			nx.rvalid = 1'b1;
			nx.rresp = RESP_OKAY;
			nx.rdata = '0;
			unique case (s_axi_araddr)
				OFF_CTRL:
					nx.rdata[1:0] = st.log_en;
				OFF_STATUS:
					nx.rdata = status_word;
				OFF_LOG:
					if (log_out_valid)
					begin
						nx.rdata[LOG_VALID] = 1'b1;
						nx.rdata[LOG_W-1:0] = log_out_data;
					end
				OFF_STORED:
					nx.rdata = {st.ba[1], st.ba[0], st.ab[1], st.ab[0]};
				default:
					nx.rresp = RESP_SLVERR;
			endcase
		end

		// Entry accepted by the FIFO frees its holding slot
		if (log_in_valid && log_in_ready)
			nx.pend[log_sel] = 1'b0;

		for (int s = 0; s < SEC_N; s++)
		begin
			live_a = st.s2[s*SEC_W+P_A +: SEC_BITS];
			live_b = st.s2[s*SEC_W+P_B +: SEC_BITS];
			edge_ab = settled && st.s2[s*SEC_W+P_CAB] &&
				!st.clk_prev[s][0];
			edge_ba = settled && st.s2[s*SEC_W+P_CBA] &&
				!st.clk_prev[s][1];
			nx.clk_prev[s] = {st.s2[s*SEC_W+P_CBA], st.s2[s*SEC_W+P_CAB]};

			// Capture ignores enable and way select entirely
			if (edge_ab)
				nx.ab[s] = live_a;
			if (edge_ba)
				nx.ba[s] = live_b;

			// Drive choice, registered so a select change cannot glitch
			nx.a_oe[s] = 1'b0;
			nx.b_oe[s] = 1'b0;
			if (!st.s2[s*SEC_W+P_OEN])
			begin
				if (st.s2[s*SEC_W+P_DIR])
				begin
					nx.b_oe[s] = 1'b1;
					if (st.s2[s*SEC_W+P_SAB])
						nx.b_out[s] = st.ab[s];
					else
						nx.b_out[s] = live_a;
				end
				else
				begin
					nx.a_oe[s] = 1'b1;
					if (st.s2[s*SEC_W+P_SBA])
						nx.a_out[s] = st.ba[s];
					else
						nx.a_out[s] = live_b;
				end
			end

			// Log captures; a second capture before the slot drains overflows
			if (edge_ab && st.log_en[0])
			begin
				if (nx.pend[s])
					nx.overflow = 1'b1;
				nx.pend[s] = 1'b1;
				nx.hold[s] = {1'b0, 1'(s), live_a};
			end
			if (edge_ba && st.log_en[1])
			begin
				if (nx.pend[SEC_N+s])
					nx.overflow = 1'b1;
				nx.pend[SEC_N+s] = 1'b1;
				nx.hold[SEC_N+s] = {1'b1, 1'(s), live_b};
			end
		end

		// Reset clears control and output state; stored data is kept
		if (sys_rst)
		begin
			nx.settle = '0;
			nx.a_out = '0;
			nx.b_out = '0;
			nx.a_oe = '0;
			nx.b_oe = '0;
			nx.log_en = CTRL_RST;
			nx.overflow = 1'b0;
			nx.pend = '0;
			nx.aw_seen = 1'b0;
			nx.w_seen = 1'b0;
			nx.bvalid = 1'b0;
			nx.bresp = RESP_OKAY;
			nx.rvalid = 1'b0;
			nx.rdata = '0;
			nx.rresp = RESP_OKAY;
			nx.ab = st.ab;
			nx.ba = st.ba;
		end
	end

	always_ff @(posedge core_clk)
		st <= nx;

	rbt_fifo #(
		.WIDTH (LOG_W),
		.DEPTH (LOG_FIFO_DEPTH)
	) u_log_fifo (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.in_valid  (log_in_valid),
		.in_ready  (log_in_ready),
		.in_data   (log_in_data),
		.out_valid (log_out_valid),
		.out_ready (log_out_ready),
		.out_data  (log_out_data)
	);

	// Pin outputs
	always_comb
	begin
		for (int s = 0; s < SEC_N; s++)
		begin
			port_a_lines_out[s*SEC_BITS +: SEC_BITS] = st.a_out[s];
			port_b_lines_out[s*SEC_BITS +: SEC_BITS] = st.b_out[s];
			port_a_lines_oe[s*SEC_BITS +: SEC_BITS] = {SEC_BITS{st.a_oe[s]}};
			port_b_lines_oe[s*SEC_BITS +: SEC_BITS] = {SEC_BITS{st.b_oe[s]}};
		end
	end

	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata  = st.rdata;
	assign s_axi_rresp  = st.rresp;
endmodule : rbt_top
`default_nettype wire

/* File: dv/rbt_checker.sv */
// Concurrent checks on the transceiver ports
`timescale 1ns/1ps
`default_nettype none
module rbt_checker
(
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [15:0] port_a_lines_in,
	input wire logic [15:0] port_a_lines_out,
	input wire logic [15:0] port_a_lines_oe,
	input wire logic [15:0] port_b_lines_in,
	input wire logic [15:0] port_b_lines_out,
	input wire logic [15:0] port_b_lines_oe,
	input wire logic [1:0]  output_enable_n,
	input wire logic [1:0]  transfer_way_select,
	input wire logic [1:0]  a_to_b_source_select,
	input wire logic [1:0]  b_to_a_source_select,
	input wire logic [1:0]  b_to_a_capture_clock,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid
);
	logic [2:0] age;
	logic [7:0] cba_hist;
	logic [3:0] sel_hist;
	logic [1:0] drv_a;
	logic [1:0] drv_b;
	assign drv_a = ~output_enable_n & ~transfer_way_select;
	assign drv_b = ~output_enable_n & transfer_way_select;
	// Capture-clock and stored-select history for the hold check
	always_ff @(posedge core_clk)
	begin
		cba_hist <= {cba_hist[6:0], b_to_a_capture_clock[0]};
		sel_hist <= {sel_hist[2:0], drv_a[0] & b_to_a_source_select[0]};
		age      <= sys_rst ? 3'h0 : age + {2'h0, age != 3'h7};
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	a_never_both: assert property (
		(port_a_lines_oe & port_b_lines_oe) == 16'h0)
		else $error("Both buses driven");
	a_off_quiet: assert property (
		age == 3'h7 && $past(output_enable_n[0], 3)
		|-> (port_a_lines_oe[7:0] | port_b_lines_oe[7:0]) == 8'h0)
		else $error("Drive while disabled");
	a_drive_b_side: assert property (
		age == 3'h7 && $past(drv_b[1], 3) |-> port_b_lines_oe[15:8] == 8'hFF)
		else $error("B side not driven");
	a_live_to_a: assert property (
		age == 3'h7 && $past(drv_a[0] & ~b_to_a_source_select[0], 3)
		|-> port_a_lines_out[7:0] == $past(port_b_lines_in[7:0], 3))
		else $error("Live B data wrong");
	a_live_to_b: assert property (
		age == 3'h7 && $past(drv_b[1] & ~a_to_b_source_select[1], 3)
		|-> port_b_lines_out[15:8] == $past(port_a_lines_in[15:8], 3))
		else $error("Live A data wrong");
	a_stored_hold: assert property (
		age == 3'h7 && sel_hist[3:2] == 2'h3
		&& (cba_hist == 8'h0 || cba_hist == 8'hFF)
		|-> $stable(port_a_lines_out[7:0]))
		else $error("Stored data moved");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	a_read_busy: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("Read taken while busy");
endmodule : rbt_checker
`default_nettype wire

/* File: dv/rbt_bus_model.sv */
// Far-side logic driving both buses
`timescale 1ns/1ps
`default_nettype none
module rbt_bus_model
(
	input  wire logic [15:0] a_drv,
	input  wire logic [15:0] b_drv,
	input  wire logic [15:0] port_a_lines_out,
	input  wire logic [15:0] port_a_lines_oe,
	input  wire logic [15:0] port_b_lines_out,
	input  wire logic [15:0] port_b_lines_oe,
	output logic      [15:0] port_a_lines_in,
	output logic      [15:0] port_b_lines_in
);
	// Far side lets go of every line the block drives
	assign port_a_lines_in = (port_a_lines_oe & port_a_lines_out)
		| (~port_a_lines_oe & a_drv);
	assign port_b_lines_in = (port_b_lines_oe & port_b_lines_out)
		| (~port_b_lines_oe & b_drv);
endmodule : rbt_bus_model
`default_nettype wire

/* File: dv/rbt_tb_top.sv */
// Self-checking testbench for the bus transceiver
`timescale 1ns/1ps
`default_nettype none
module rbt_tb_top
	import rbt_pkg::*;
;
	logic        core_clk;
	logic        sys_rst;
	logic [15:0] a_drv, b_drv, port_a_lines_in, port_b_lines_in;
	logic [15:0] port_a_lines_out, port_a_lines_oe;
	logic [15:0] port_b_lines_out, port_b_lines_oe;
	logic [1:0]  output_enable_n, transfer_way_select;
	logic [1:0]  a_to_b_source_select, b_to_a_source_select;
	logic [1:0]  a_to_b_capture_clock, b_to_a_capture_clock;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          err_total = 0;
	int          total_checks = 0;
	int          i;
	rbt_top dut (.core_clk, .sys_rst, .port_a_lines_in, .port_a_lines_out,
		.port_a_lines_oe, .port_b_lines_in, .port_b_lines_out, .port_b_lines_oe,
		.output_enable_n, .transfer_way_select, .a_to_b_source_select,
		.b_to_a_source_select, .a_to_b_capture_clock, .b_to_a_capture_clock,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	rbt_bus_model far (.a_drv, .b_drv, .port_a_lines_out, .port_a_lines_oe,
		.port_b_lines_out, .port_b_lines_oe, .port_a_lines_in, .port_b_lines_in);
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic look(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : look
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic drive(input logic [15:0] a, b,
		input logic [1:0] oe, dr, ab, ba);
		@(posedge core_clk);
		a_drv <= a;
		b_drv <= b;
		output_enable_n <= oe;
		transfer_way_select <= dr;
		a_to_b_source_select <= ab;
		b_to_a_source_select <= ba;
	endtask : drive
	task automatic cap(input logic [1:0] ab, ba);
		repeat (3) @(posedge core_clk);
		a_to_b_capture_clock <= ab;
		b_to_a_capture_clock <= ba;
		repeat (2) @(posedge core_clk);
		a_to_b_capture_clock <= 2'h0;
		b_to_a_capture_clock <= 2'h0;
		repeat (3) @(posedge core_clk);
	endtask : cap
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		logic [1:0] p;
		p = 2'h3;
		@(posedge core_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (p != 2'h0)
		begin
			@(negedge core_clk);
			p = p & ~{s_axi_awready, s_axi_wready};
			@(posedge core_clk);
			s_axi_awvalid <= p[1];
			s_axi_wvalid <= p[0];
		end
		@(negedge core_clk);
		while (!s_axi_bvalid) @(negedge core_clk);
		rs = s_axi_bresp;
		@(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [3:0] ad);
		@(posedge core_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(negedge core_clk);
		while (!s_axi_arready) @(negedge core_clk);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		@(negedge core_clk);
		while (!s_axi_rvalid) @(negedge core_clk);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask : rdr
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	initial
	begin
		#2_000_000;
		err_total++;
		summarize();
	end
	initial
	begin
		{a_drv, b_drv, transfer_way_select, a_to_b_source_select,
			b_to_a_source_select, a_to_b_capture_clock, b_to_a_capture_clock,
			s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid,
			s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		output_enable_n = 2'h3;
		s_axi_wstrb = 4'hF;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdr(OFF_CTRL);
		chk("ctrl reset", {30'h0, CTRL_RST}, rd);
		drive(16'h2211, 16'h4433, 2'h3, 2'h0, 2'h0, 2'h0);
		cap(2'h3, 2'h3);
		look(1);
		chk("oe off", 32'h0,
			{port_a_lines_oe, port_b_lines_oe});
		rdr(OFF_STORED);
		chk("stored", 32'h4433_2211, rd);
		drive(16'h6655, 16'h8877, 2'h0, 2'h2, 2'h3, 2'h3);
		look(4);
		chk("oe split", 32'hFF00_00FF,
			{port_b_lines_oe, port_a_lines_oe});
		chk("stored out", 32'h2233, 32'({port_b_lines_out[15:8],
			port_a_lines_out[7:0]}));
		drive(16'h6655, 16'h8877, 2'h0, 2'h2, 2'h0, 2'h0);
		look(4);
		chk("live out", 32'h6677, 32'({port_b_lines_out[15:8],
			port_a_lines_out[7:0]}));
		cap(2'h2, 2'h1);
		drive(16'h6655, 16'h8877, 2'h0, 2'h2, 2'h3, 2'h3);
		for (i = 0; i < 6; i++)
		begin
			look(1);
			chk("switch", 32'h6677, 32'({port_b_lines_out[15:8],
				port_a_lines_out[7:0]}));
		end
		// A lines take three cycles to turn around before live A reaches B
		drive(16'hBEEF, 16'h8877, 2'h0, 2'h3, 2'h0, 2'h0);
		look(6);
		chk("wide", 32'hFFFF_BEEF,
			{port_b_lines_oe, port_b_lines_out});
		wr(OFF_STATUS, 32'h1);
		chk("ro write", 32'(RESP_SLVERR), 32'(rs));
		rdr(4'h2);
		chk("bad addr", 32'(RESP_SLVERR), 32'(rs));
		wr(OFF_CTRL, 32'h1);
		for (i = 0; i < 10; i++)
		begin
			drive(16'(i), 16'h0, 2'h3, 2'h0, 2'h0, 2'h0);
			cap(2'h1, 2'h0);
		end
		rdr(OFF_STATUS);
		chk("log full", 32'h3, rd & 32'h3);
		for (i = 0; i < 10; i++)
		begin
			rdr(OFF_LOG);
			chk("log entry", (i == 9) ? 32'h0
				: 32'h8000_0000 | 32'((i < 8) ? i : 9), rd);
		end
		wr(OFF_CTRL, 32'h5);
		rdr(OFF_STATUS);
		chk("ovf clear", 32'h0, rd & 32'h2);
		rdr(OFF_CTRL);
		chk("ctrl", 32'h1, rd);
		s_axi_wstrb <= 4'h0;
		wr(OFF_CTRL, 32'h2);
		s_axi_wstrb <= 4'hF;
		rdr(OFF_CTRL);
		chk("strobe off", 32'h1, rd);
		wr(OFF_CTRL, 32'h2);
		drive(16'h0, 16'hA500, 2'h3, 2'h0, 2'h0, 2'h0);
		cap(2'h0, 2'h2);
		rdr(OFF_LOG);
		chk("log b side", 32'h8000_03A5, rd);
		rdr(OFF_STATUS);
		chk("status pins", 32'h0000_1100, rd & 32'h0000_FFF3);
		summarize();
	end
endmodule : rbt_tb_top
bind rbt_top rbt_checker chk_i (.core_clk, .sys_rst, .port_a_lines_in,
	.port_a_lines_out, .port_a_lines_oe, .port_b_lines_in, .port_b_lines_out,
	.port_b_lines_oe, .output_enable_n, .transfer_way_select,
	.a_to_b_source_select, .b_to_a_source_select, .b_to_a_capture_clock,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
